// ---- dsm_delay_timer.sv ----
module dsm_delay_timer (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // control
  input  wire logic        tick,
  input  wire logic        arm,
  input  wire logic [15:0] delay,
  // result
  output logic             done
);
  import dsm_pkg::*;

  logic [15:0] count_q;

  // restart whenever the condition falls away before expiry
  always_ff @(posedge clock) begin
    if (sys_rst || !arm) begin
      count_q <= '0;
    end else if (tick && count_q != 16'hFFFF) begin
      count_q <= count_q + 16'h0001;
    end
  end

  assign done = arm && (count_q >= delay);

endmodule : dsm_delay_timer

// ---- dsm_elapsed_counter.sv ----
module dsm_elapsed_counter (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // control
  input  wire logic        clear,
  input  wire logic        advance,
  // count
  output logic [15:0]      count
);
  import dsm_pkg::*;

  logic [15:0] count_q;

  // saturates so a long run never wraps back below a target
  always_ff @(posedge clock) begin
    if (sys_rst || clear) begin
      count_q <= '0;
    end else if (advance && count_q != 16'hFFFF) begin
      count_q <= count_q + 16'h0001;
    end
  end

  assign count = count_q;

endmodule : dsm_elapsed_counter

// ---- dsm_monitor.sv ----
module dsm_monitor #(
  parameter int unsigned TICK_LEN = dsm_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic               clock,
  input  wire logic               sys_rst,
  // settings
  input  wire dsm_pkg::dsm_cfg_t  cfg,
  // drive context
  input  wire logic               run_request,
  input  wire logic               vf_control,
  input  wire logic               pid_is_source,
  input  wire logic [15:0]        set_freq,
  input  wire logic [15:0]        out_freq,
  // digitised samples
  input  wire logic [9:0]         analog_input_one,
  input  wire logic [9:0]         analog_input_two,
  input  wire logic [9:0]         analog_input_three,
  input  wire logic [7:0]         heatsink_temp,
  // status
  output dsm_pkg::dsm_status_t    status
);
  import dsm_pkg::*;

  // fills every bit below the highest set bit
  function automatic logic [3:0] smear(input logic [3:0] v);
    logic [3:0] r;
    r = v;
    r = r | {1'b0, r[3:1]};
    r = r | {2'b00, r[3:2]};
    return r;
  endfunction : smear

  // caps a depth setting at the legal maximum
  function automatic logic [3:0] clamp_depth(input logic [3:0] v);
    return (v > RANDOM_DEPTH_MAX) ? RANDOM_DEPTH_MAX : v;
  endfunction : clamp_depth

  localparam logic [31:0] TICK_LAST = 32'(TICK_LEN - 1);
  localparam logic [7:0]  MIN_LAST  = 8'(MIN_TENTH_TICKS - 1);

  dsm_state_t  state_q;
  dsm_state_t  state_d;
  dsm_status_t status_q;
  logic [31:0] tick_cnt_q;
  logic        tick_q;
  logic [7:0]  min_cnt_q;
  logic        min_tick_q;
  logic        run_req_q;
  logic        start_evt;
  logic        dormancy_on;
  logic        sleep_arm;
  logic        wake_arm;
  logic        sleep_done;
  logic        wake_done;
  logic [15:0] run_minutes;
  logic [9:0]  ain_sel;
  logic [25:0] dur_prod;
  logic [25:0] dur_scaled;
  logic [15:0] duration_q;
  logic        expired;
  logic [15:0] switch_freq;
  logic [15:0] lfsr_q;
  logic [3:0]  depth;
  logic [3:0]  off_raw;

  // control tick, every 0.1 s
  always_ff @(posedge clock) begin
    if (sys_rst || tick_cnt_q == TICK_LAST) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= (tick_cnt_q == TICK_LAST);
    end
  end

  // tenth-of-minute tick, only while running so run time is drive time
  always_ff @(posedge clock) begin
    if (sys_rst || start_evt) begin
      min_cnt_q  <= '0;
      min_tick_q <= 1'b0;
    end else if (tick_q && state_q == DSM_ST_RUN) begin
      min_tick_q <= (min_cnt_q == MIN_LAST);
      if (min_cnt_q == MIN_LAST) begin
        min_cnt_q <= '0;
      end else begin
        min_cnt_q <= min_cnt_q + 8'h01;
      end
    end else begin
      min_tick_q <= 1'b0;
    end
  end

  // run request edge detect
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      run_req_q <= 1'b0;
    end else begin
      run_req_q <= run_request;
    end
  end

  assign dormancy_on = (cfg.wakeup_level != '0) ||
                       (cfg.sleep_frequency != '0);
  assign sleep_arm   = dormancy_on && state_q == DSM_ST_RUN &&
                       set_freq <= cfg.sleep_frequency;
  assign wake_arm    = dormancy_on && state_q == DSM_ST_DORMANT &&
                       run_request &&
                       set_freq >= cfg.wakeup_level;

  dsm_delay_timer u_sleep_delay (
    .clock   (clock),
    .sys_rst (sys_rst),
    .tick    (tick_q),
    .arm     (sleep_arm),
    .delay   (cfg.sleep_delay),
    .done    (sleep_done)
  );

  dsm_delay_timer u_wake_delay (
    .clock   (clock),
    .sys_rst (sys_rst),
    .tick    (tick_q),
    .arm     (wake_arm),
    .delay   (cfg.wakeup_delay),
    .done    (wake_done)
  );

  // one counter serves both the stop timer and the run time flag
  dsm_elapsed_counter u_run_time (
    .clock   (clock),
    .sys_rst (sys_rst),
    .clear   (start_evt),
    .advance (min_tick_q),
    .count   (run_minutes)
  );

  // timer duration source
  always_comb begin
    case (cfg.timer_duration_source)
      2'h1:    ain_sel = analog_input_one;
      2'h2:    ain_sel = analog_input_two;
      2'h3:    ain_sel = analog_input_three;
      default: ain_sel = AIN_FULL_SCALE;
    endcase
  end

  assign dur_prod   = cfg.timer_duration_setting * ain_sel;
  assign dur_scaled = dur_prod / 26'(AIN_FULL_SCALE);

  // registered to keep the divider off the stop path
  // lags a setting change by one cycle, well before any minute tick
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      duration_q <= '0;
    end else if (cfg.timer_duration_source == 2'h0) begin
      duration_q <= cfg.timer_duration_setting;
    end else if (dur_scaled > 26'h000FFFF) begin
      duration_q <= 16'hFFFF;
    end else begin
      duration_q <= dur_scaled[15:0];
    end
  end

  assign expired = cfg.run_timer_enable && state_q == DSM_ST_RUN &&
                   !start_evt && run_minutes >= duration_q;

  // drive sequencing
  always_comb begin
    state_d   = state_q;
    start_evt = 1'b0;
    case (state_q)
      DSM_ST_STOP: begin
        if (run_request && !run_req_q) begin
          state_d   = DSM_ST_RUN;
          start_evt = 1'b1;
        end
      end
      DSM_ST_RUN: begin
        if (!run_request) begin
          state_d = DSM_ST_STOP;
        end else if (expired) begin
          state_d = DSM_ST_EXPIRED;
        end else if (sleep_done) begin
          state_d = DSM_ST_DORMANT;
        end
      end
      DSM_ST_DORMANT: begin
        if (!run_request) begin
          state_d = DSM_ST_STOP;
        end else if (wake_done) begin
          state_d   = DSM_ST_RUN;
          start_evt = 1'b1;
        end
      end
      DSM_ST_EXPIRED: begin
        // held stopped until the run command is withdrawn
        if (!run_request) begin
          state_d = DSM_ST_STOP;
        end
      end
      default: begin
        state_d = DSM_ST_STOP;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q <= DSM_ST_STOP;
    end else begin
      state_q <= state_d;
    end
  end

  // drive sequencing outputs
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      status_q.drive_run          <= 1'b0;
      status_q.timer_expired      <= 1'b0;
      status_q.dormant            <= 1'b0;
      status_q.run_time_reached   <= 1'b0;
      status_q.pid_compute_enable <= 1'b0;
    end else begin
      status_q.drive_run        <= (state_d == DSM_ST_RUN);
      status_q.timer_expired    <= (state_d == DSM_ST_EXPIRED);
      status_q.dormant          <= (state_d == DSM_ST_DORMANT);
      status_q.run_time_reached <= (state_q == DSM_ST_RUN) &&
                                   !start_evt &&
                                   (run_minutes >=
                                    cfg.run_time_target);
      if (state_d == DSM_ST_DORMANT) begin
        status_q.pid_compute_enable <= pid_is_source &&
                                       cfg.stop_state_pid_enable;
      end else begin
        status_q.pid_compute_enable <= pid_is_source &&
                                       (state_d == DSM_ST_RUN);
      end
    end
  end

  // analog window and heatsink flags, sampled on the tick
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      status_q.ain_out_of_range <= 1'b0;
      status_q.module_temp_hot  <= 1'b0;
    end else if (tick_q) begin
      status_q.ain_out_of_range <=
        (analog_input_one > cfg.ain_one_upper_limit) ||
        (analog_input_one < cfg.ain_one_lower_limit);
      status_q.module_temp_hot <=
        (heatsink_temp >= cfg.heatsink_temp_threshold);
    end
  end

  // cooling fan
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      status_q.fan_on <= 1'b0;
    end else if (cfg.fan_mode_select) begin
      status_q.fan_on <= 1'b1;
    end else if (state_d == DSM_ST_RUN) begin
      // next state, so the fan rises in the same cycle as drive_run
      status_q.fan_on <= 1'b1;
    end else if (tick_q) begin
      // exactly 40 C counts as cool
      status_q.fan_on <= (heatsink_temp > FAN_STOP_TEMP);
    end
  end

  // modulation selection
  assign switch_freq = (cfg.discontinuous_switch_freq > SWITCH_FREQ_MAX) ?
                       SWITCH_FREQ_MAX :
                       cfg.discontinuous_switch_freq;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      status_q.discontinuous_modulation <= 1'b0;
      status_q.sync_modulation          <= 1'b0;
    end else begin
      status_q.discontinuous_modulation <= vf_control &&
                                           out_freq >= switch_freq;
      status_q.sync_modulation <= vf_control &&
                                  cfg.modulation_sync_select &&
                                  out_freq > SYNC_FREQ_MIN;
    end
  end

  // dead zone, fast limit; an out-of-range code falls back to mode 1
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      status_q.deadtime_mode      <= DEADTIME_DEF;
      status_q.fast_current_limit <= FAST_LIMIT_DEF;
    end else begin
      status_q.deadtime_mode <= (cfg.deadtime_comp_mode == 2'h3) ?
                                DEADTIME_DEF :
                                cfg.deadtime_comp_mode;
      status_q.fast_current_limit <= cfg.fast_current_limit_enable;
    end
  end

  // carrier randomisation
  assign depth   = clamp_depth(cfg.carrier_random_depth);
  assign off_raw = lfsr_q[3:0] & smear(depth);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lfsr_q <= LFSR_SEED;
    end else begin
      lfsr_q <= {lfsr_q[14:0],
                 lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    end
  end

  // offset kept within the depth; a new value once per tick
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      status_q.random_enable <= 1'b0;
      status_q.random_depth  <= '0;
      status_q.random_offset <= '0;
    end else begin
      status_q.random_enable <= (depth != 4'h0);
      status_q.random_depth  <= depth;
      if (depth == 4'h0) begin
        status_q.random_offset <= '0;
      end else if (tick_q) begin
        status_q.random_offset <= (off_raw > depth) ?
                                  {1'b0, off_raw[3:1]} : off_raw;
      end
    end
  end

  assign status = status_q;

endmodule : dsm_monitor

// ---- dsm_monitor_sva.sv ----
module dsm_monitor_sva #(
  parameter int unsigned TICK_LEN = 25
) (
  // clock and reset
  input wire logic                 clock,
  input wire logic                 sys_rst,
  // watched ports
  input wire dsm_pkg::dsm_cfg_t    cfg,
  input wire logic                 run_request,
  input wire logic                 vf_control,
  input wire logic [15:0]          out_freq,
  input wire dsm_pkg::dsm_status_t status
);
  import dsm_pkg::*;
  logic [15:0] sw_lim;
  logic [3:0]  dep_lim;
  logic [1:0]  dead_lim;
  // out of range settings fall back as the design clamps them
  assign sw_lim = (cfg.discontinuous_switch_freq > SWITCH_FREQ_MAX) ?
                  SWITCH_FREQ_MAX : cfg.discontinuous_switch_freq;
  assign dep_lim = (cfg.carrier_random_depth > RANDOM_DEPTH_MAX) ?
                   RANDOM_DEPTH_MAX : cfg.carrier_random_depth;
  assign dead_lim = (cfg.deadtime_comp_mode == 2'h3) ?
                    DEADTIME_DEF : cfg.deadtime_comp_mode;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence start_req;
    run_request && !$past(run_request) && !status.drive_run &&
    !status.dormant && !status.timer_expired;
  endsequence
  fan_run_a: assert property (status.drive_run |-> status.fan_on)
    else $error("fan off while running");
  fan_always_a: assert property (cfg.fan_mode_select |=>
    status.fan_on)
    else $error("fan off in continuous mode");
  sync_mod_a: assert property (!$past(sys_rst) |->
    status.sync_modulation == $past(vf_control &&
    cfg.modulation_sync_select && out_freq > SYNC_FREQ_MIN))
    else $error("synchronous modulation wrong");
  disc_mod_a: assert property (!$past(sys_rst) |->
    status.discontinuous_modulation == $past(vf_control && out_freq >= sw_lim))
    else $error("discontinuous modulation wrong");
  rand_depth_a: assert property (!$past(sys_rst) |->
    status.random_enable == $past(cfg.carrier_random_depth != 4'h0) &&
    status.random_depth == $past(dep_lim))
    else $error("random depth wrong");
  dead_mode_a: assert property (!$past(sys_rst) |->
    status.deadtime_mode == $past(dead_lim))
    else $error("deadtime mode wrong");
  fast_limit_a: assert property (!$past(sys_rst) |->
    status.fast_current_limit == $past(cfg.fast_current_limit_enable))
    else $error("fast limit wrong");
  run_start_a: assert property (start_req |=> status.drive_run)
    else $error("drive did not start");
  expiry_stop_a: assert property ($rose(status.timer_expired) |->
    !status.drive_run && $past(status.drive_run))
    else $error("expiry without stop");
  no_sleep_a: assert property (cfg.sleep_frequency == 16'h0000 &&
    cfg.wakeup_level == 16'h0000 && !status.dormant |=> !status.dormant)
    else $error("dormant while disabled");
  cover property ($rose(status.timer_expired));
  cover property ($rose(status.dormant));
  cover property ($rose(status.run_time_reached));
  cover property ($rose(status.ain_out_of_range));
endmodule : dsm_monitor_sva

bind dsm_monitor dsm_monitor_sva #(.TICK_LEN(TICK_LEN)) u_sva (
  .clock(clock), .sys_rst(sys_rst), .cfg(cfg), .run_request(run_request),
  .vf_control(vf_control), .out_freq(out_freq), .status(status));

// ---- dsm_monitor_test.sv ----
module dsm_monitor_test;
  timeunit 1ns;
  timeprecision 1ns;
  import dsm_pkg::*;
  localparam int unsigned TL   = 25;
  localparam int          MINT = 60 * TL;
  logic        clock, sys_rst, run_request, vf_control, pid_is_source;
  dsm_cfg_t    cfg;
  dsm_status_t status;
  logic [15:0] set_freq, out_freq;
  logic [9:0]  analog_input_one, analog_input_two, analog_input_three;
  logic [7:0]  heatsink_temp;
  int          mismatches, n_compared;

  dsm_monitor #(.TICK_LEN(TL)) u_dut (
    .clock(clock), .sys_rst(sys_rst), .cfg(cfg), .run_request(run_request),
    .vf_control(vf_control), .pid_is_source(pid_is_source),
    .set_freq(set_freq), .out_freq(out_freq),
    .analog_input_one(analog_input_one), .analog_input_two(analog_input_two),
    .analog_input_three(analog_input_three), .heatsink_temp(heatsink_temp),
    .status(status));

  always #20 clock = ~clock;

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic near(input int v, input int c);
    return v > c - 2 * TL && v < c + 2 * TL;
  endfunction : near

  // sample 1 ns after the edge so the design's updates have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc

  function automatic logic pick(input int sel);
    case (sel)
      0: return status.drive_run;
      1: return status.dormant;
      default: return status.run_time_reached;
    endcase
  endfunction : pick

  task automatic wait_for(input int sel, input logic lvl, input int bound,
                          output int n);
    n = 0;
    while (pick(sel) !== lvl) begin
      cyc(1);
      n++;
      if (n > bound) begin
        mismatches++;
        $display("[FAIL] wait %0d expected %h seen %h", sel, lvl, pick(sel));
        end_of_test();
      end
    end
  endtask : wait_for

  task automatic t_pwm();
    logic [3:0]  d;
    logic [15:0] sw, of;
    for (int i = 0; i < 16; i++) begin
      d = 4'(i);
      @(posedge clock);
      cfg.carrier_random_depth <= d;
      cfg.deadtime_comp_mode <= d[1:0];
      cfg.fast_current_limit_enable <= d[0];
      cyc(2);
      check("rand en", status.random_enable, d != 4'h0);
      if (d > RANDOM_DEPTH_MAX) d = RANDOM_DEPTH_MAX;
      check("rand depth", status.random_depth, d);
      check("dead", status.deadtime_mode, (i % 4 == 3) ? 1 : i % 4);
      check("fast", status.fast_current_limit, i % 2);
      cyc(TL + 2);
      check("rand offs", status.random_offset <= d, 1'b1);
    end
    for (int i = 0; i < 6; i++) begin
      sw = (i < 2) ? SWITCH_FREQ_DEF : 16'h07D0;
      of = ((i < 2) ? SWITCH_FREQ_DEF : SWITCH_FREQ_MAX) - 16'(1 - i % 2);
      @(posedge clock);
      vf_control <= (i < 4);
      cfg.discontinuous_switch_freq <= sw;
      cfg.modulation_sync_select <= (i != 3);
      out_freq <= of;
      cyc(2);
      check("disc", status.discontinuous_modulation, i % 2 && i < 4);
      @(posedge clock);
      out_freq <= SYNC_FREQ_MIN + 16'(i % 2);
      cyc(2);
      check("sync", status.sync_modulation, i == 1);
    end
    @(posedge clock);
    vf_control <= 1'b1;
  endtask : t_pwm

  task automatic t_sense();
    logic [9:0] a;
    logic [7:0] t;
    for (int k = 0; k < 6; k++) begin
      a = (k < 3) ? AIN_LOWER_DEF - 10'h001 + 10'(k) :
                    AIN_UPPER_DEF - 10'h004 + 10'(k);
      t = (k < 3) ? FAN_STOP_TEMP - 8'h01 + 8'(k) :
                    TEMP_THRESH_DEF - 8'h04 + 8'(k);
      @(posedge clock);
      analog_input_one <= a;
      heatsink_temp <= t;
      cyc(TL + 3);
      check("ain range", status.ain_out_of_range, k == 0 || k == 5);
      check("temp hot", status.module_temp_hot, t >= TEMP_THRESH_DEF);
      check("fan stop", status.fan_on, t > FAN_STOP_TEMP);
    end
    @(posedge clock);
    heatsink_temp <= 8'h1E;
    cfg.fan_mode_select <= 1'b1;
    cyc(TL + 3);
    check("fan cont", status.fan_on, 1'b1);
    @(posedge clock);
    cfg.fan_mode_select <= 1'b0;
  endtask : t_sense

  task automatic t_timer();
    int n, m;
    @(posedge clock);
    cfg.run_timer_enable <= 1'b1;
    cfg.timer_duration_setting <= 16'h0002;
    cfg.run_time_target <= 16'h0001;
    run_request <= 1'b1;
    cyc(2);
    check("start", status.drive_run, 1'b1);
    wait_for(2, 1'b1, 2 * MINT, n);
    check("reach time", near(n, MINT), 1'b1);
    wait_for(0, 1'b0, 2 * MINT, m);
    m = m + n + 2;
    check("exp time", near(m, 2 * MINT), 1'b1);
    check("expired", status.timer_expired, 1'b1);
    cyc(TL);
    check("stay stopped", status.drive_run, 1'b0);
    // analog source scales the setting: 0.4 min at half scale runs 0.2 min
    @(posedge clock);
    run_request <= 1'b0;
    cfg.timer_duration_source <= 2'h1;
    cfg.timer_duration_setting <= 16'h0004;
    analog_input_one <= 10'h1F4;
    cyc(3);
    check("exp clear", status.timer_expired, 1'b0);
    @(posedge clock);
    run_request <= 1'b1;
    cyc(2);
    wait_for(0, 1'b0, 3 * MINT, n);
    n = n + 2;
    check("ain time", near(n, 2 * MINT), 1'b1);
    // second analog source reads zero, so the run expires at once
    @(posedge clock);
    run_request <= 1'b0;
    cfg.timer_duration_source <= 2'h2;
    cyc(3);
    @(posedge clock);
    run_request <= 1'b1;
    cyc(4);
    check("ain2 zero", status.timer_expired, 1'b1);
    @(posedge clock);
    run_request <= 1'b0;
    cfg.run_timer_enable <= 1'b0;
    cyc(3);
  endtask : t_timer

  task automatic t_sleep();
    int n;
    @(posedge clock);
    cfg.sleep_frequency <= 16'h03E8;
    cfg.sleep_delay <= 16'h0004;
    cfg.wakeup_level <= 16'h07D0;
    cfg.wakeup_delay <= 16'h0003;
    cfg.stop_state_pid_enable <= 1'b1;
    pid_is_source <= 1'b1;
    set_freq <= 16'h05DC;
    run_request <= 1'b1;
    cyc(5 * TL);
    check("awake", status.dormant, 1'b0);
    // two short dips, each under the delay, must not add up
    repeat (2) begin
      @(posedge clock);
      set_freq <= 16'h03E8;
      cyc(3 * TL - 5);
      @(posedge clock);
      set_freq <= 16'h05DC;
      cyc(2);
    end
    check("restart", status.dormant, 1'b0);
    @(posedge clock);
    set_freq <= 16'h03E8;
    wait_for(1, 1'b1, 5 * TL + 5, n);
    check("sleep delay", n >= 3 * TL, 1'b1);
    check("sleep stop", status.drive_run, 1'b0);
    check("pid on", status.pid_compute_enable, 1'b1);
    @(posedge clock);
    cfg.stop_state_pid_enable <= 1'b0;
    set_freq <= 16'h07CF;
    cyc(5 * TL);
    check("pid off", status.pid_compute_enable, 1'b0);
    check("no wake", status.dormant, 1'b1);
    @(posedge clock);
    set_freq <= 16'h07D0;
    wait_for(0, 1'b1, 4 * TL + 5, n);
    check("wake delay", n >= 2 * TL, 1'b1);
    check("woken", status.dormant, 1'b0);
    @(posedge clock);
    cfg.sleep_frequency <= 16'h0000;
    cfg.wakeup_level <= 16'h0000;
    set_freq <= 16'h0000;
    cyc(8 * TL);
    check("disabled", status.drive_run && !status.dormant, 1'b1);
    @(posedge clock);
    run_request <= 1'b0;
    cyc(3);
  endtask : t_sleep

  initial begin
    clock = 1'b0;
    sys_rst = 1'b1;
    cfg = '0;
    cfg.ain_one_lower_limit = AIN_LOWER_DEF;
    cfg.ain_one_upper_limit = AIN_UPPER_DEF;
    cfg.heatsink_temp_threshold = TEMP_THRESH_DEF;
    cfg.discontinuous_switch_freq = SWITCH_FREQ_DEF;
    run_request = 1'b0;
    vf_control = 1'b1;
    pid_is_source = 1'b0;
    set_freq = 16'h0000;
    out_freq = 16'h0000;
    analog_input_one = 10'h1F4;
    analog_input_two = 10'h000;
    analog_input_three = 10'h3E8;
    heatsink_temp = 8'h19;
    repeat (19) @(posedge clock);
    #1;
    check("rst dead", status.deadtime_mode, DEADTIME_DEF);
    check("rst fast", status.fast_current_limit, FAST_LIMIT_DEF);
    check("rst run", status.drive_run, 1'b0);
    @(posedge clock);
    sys_rst <= 1'b0;
    cyc(2);
    t_pwm();
    t_sense();
    t_timer();
    t_sleep();
    end_of_test();
  end
endmodule : dsm_monitor_test

// ---- dsm_pkg.sv ----
package dsm_pkg;

  localparam int unsigned CLK_PERIOD_NS    = 40;
  localparam int unsigned TICK_MS          = 100;
  localparam int unsigned TICK_CYCLES      = TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned MIN_TENTH_MS     = 6000;
  localparam int unsigned MIN_TENTH_TICKS  = MIN_TENTH_MS / TICK_MS;

  // frequencies in 0.01 Hz, voltages in 0.01 V, times in 0.1 s / 0.1 min
  localparam logic [15:0] SWITCH_FREQ_MAX  = 16'h05DC;
  localparam logic [15:0] SYNC_FREQ_MIN    = 16'h2134;
  localparam logic [7:0]  FAN_STOP_TEMP    = 8'h28;
  localparam logic [9:0]  AIN_FULL_SCALE   = 10'h3E8;
  localparam logic [3:0]  RANDOM_DEPTH_MAX = 4'hA;
  localparam logic [1:0]  DEADTIME_DEF     = 2'h1;
  localparam logic [15:0] LFSR_SEED        = 16'hACE1;

  // values the settings take after a factory reset
  localparam logic [9:0]  AIN_LOWER_DEF    = 10'h136;
  localparam logic [9:0]  AIN_UPPER_DEF    = 10'h2A8;
  localparam logic [7:0]  TEMP_THRESH_DEF  = 8'h4B;
  localparam logic [15:0] SWITCH_FREQ_DEF  = 16'h04B0;
  localparam logic        FAST_LIMIT_DEF   = 1'b1;

  typedef enum logic [1:0] {
    DSM_ST_STOP    = 2'b00,
    DSM_ST_RUN     = 2'b01,
    DSM_ST_DORMANT = 2'b10,
    DSM_ST_EXPIRED = 2'b11
  } dsm_state_t;

  typedef struct packed {
    logic        run_timer_enable;
    logic [1:0]  timer_duration_source;
    logic [15:0] timer_duration_setting;
    logic [9:0]  ain_one_lower_limit;
    logic [9:0]  ain_one_upper_limit;
    logic [7:0]  heatsink_temp_threshold;
    logic        fan_mode_select;
    logic [15:0] wakeup_level;
    logic [15:0] wakeup_delay;
    logic [15:0] sleep_frequency;
    logic [15:0] sleep_delay;
    logic [15:0] run_time_target;
    logic [15:0] discontinuous_switch_freq;
    logic        modulation_sync_select;
    logic [1:0]  deadtime_comp_mode;
    logic [3:0]  carrier_random_depth;
    logic        fast_current_limit_enable;
    logic        stop_state_pid_enable;
  } dsm_cfg_t;

  typedef struct packed {
    logic        drive_run;
    logic        timer_expired;
    logic        ain_out_of_range;
    logic        module_temp_hot;
    logic        fan_on;
    logic        dormant;
    logic        run_time_reached;
    logic        pid_compute_enable;
    logic        discontinuous_modulation;
    logic        sync_modulation;
    logic        random_enable;
    logic        fast_current_limit;
    logic [1:0]  deadtime_mode;
    logic [3:0]  random_depth;
    logic [3:0]  random_offset;
  } dsm_status_t;

endpackage : dsm_pkg
